// [shared/ddri_pkg.sv]
package ddri_pkg;
   // ------------------------------------------------------------
   // Pin widths and array shape
   // ------------------------------------------------------------
   localparam int AW = 14;
   localparam int BAW = 2;
   localparam int NB = 4;
   localparam int DW = 8;
   localparam int COLW = 10;
   localparam int BANK_WORDS = 16777216;
   // Low row bits kept in the storage index; higher rows alias
   localparam int ROWK = 2;
   localparam int STORE_AW = BAW + ROWK + COLW;
   localparam int MEM_WORDS = 1 << STORE_AW;
   localparam int FIFO_DEPTH = 8;
   // ------------------------------------------------------------
   // Address fields of column and settings commands
   // ------------------------------------------------------------
   localparam int AP_BIT = 10;
   localparam int COMPLEMENTARY_READ_SIDE_STROBE_BIT = 11;
   localparam int DQSN_OFF_BIT = 10;
   localparam int BL_LSB = 0;
   localparam int BL_MSB = 2;
   localparam int AL_LSB = 3;
   localparam int AL_MSB = 5;
   localparam int CL_LSB = 4;
   localparam int CL_MSB = 6;
   localparam logic [1:0] BA_MODE = 2'h0;
   localparam logic [1:0] BA_EXT1 = 2'h1;
   localparam logic [2:0] BL4_CODE = 3'h2;
   localparam logic [2:0] BL8_CODE = 3'h3;
   localparam logic [3:0] BL4 = 4'h4;
   localparam logic [3:0] BL8 = 4'h8;
   localparam logic [2:0] CL_MIN = 3'h3;
   localparam logic [2:0] CL_MAX = 3'h6;
   localparam logic [2:0] CL_RESET = 3'h3;
   localparam logic [2:0] AL_RESET = 3'h0;
   // ------------------------------------------------------------
   // Command code {cs_n, ras_n, cas_n, we_n} and read sequencer
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_MRS = 4'b0000,
      CMD_REF = 4'b0001,
      CMD_PRE = 4'b0010,
      CMD_ACT = 4'b0011,
      CMD_WR = 4'b0100,
      CMD_RD = 4'b0101,
      CMD_NOP = 4'b0111
   } ddri_cmd_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_WAIT = 2'b01,
      RD_BURST = 2'b10
   } ddri_rd_t;
endpackage : ddri_pkg

// [src/ddri_dev.sv]
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Any edge with chip select high carries no command.
// - Command decoded from chip select, RAS, CAS and WE together.
// - Pins taken only where true clock rises and complement is low.
// - Activate carries row on A0-A13; column on A0-A9, A10 precharge flag.
// - Bank bits pick the bank, or the settings word on mode-set.
// - Write beats whose mask sample is high are not stored.
// - Extended word bit 11 set: mask pin becomes read strobe, no masking.
// - Extended word bit 10 clear enables complementary strobes; set leaves them idle.
// - Complementary read strobe drives only with read strobe and differential both on.
// - Clock enable sampled high runs the device, low stops it.
// - Termination switched on while its input samples high.
// - Device strobe edges aligned with read data; controller centres write strobe.
// - One read beat per clock crossing, both directions.
// - Commands on rising clock; write data on both strobe edges.
// - CAS latency 3, 4, 5 or 6 cycles.
// - Burst length 4 or 8 beats.
// - Read data starts additive plus CAS latency after the command.
// - Four banks of 16,777,216 bytes each; the array stores 4,096 per bank, so higher rows alias.
// - Column command flag closes the bank after its burst.
module ddri_dev (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ck,
   input wire logic i_ck_n,
   input wire logic i_cke,
   input wire logic i_cs_n,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire logic [ddri_pkg::BAW-1:0] i_ba,
   input wire logic [ddri_pkg::AW-1:0] i_a,
   input wire logic i_odt,
   input wire logic [ddri_pkg::DW-1:0] i_dq,
   input wire logic i_dqs,
   input wire logic i_dm,
   output logic [ddri_pkg::DW-1:0] o_dq,
   output logic o_dq_oe_n,
   output logic o_dqs,
   output logic o_dqs_oe_n,
   output logic o_dqs_n,
   output logic o_dqs_n_oe_n,
   output logic o_complementary_read_side_strobe,
   output logic o_complementary_read_side_strobe_oe_n,
   output logic o_complementary_read_side_strobe_n,
   output logic o_complementary_read_side_strobe_n_oe_n,
   output logic o_odt_on,
   output logic o_clk_active,
   output logic [ddri_pkg::NB-1:0] o_bank_open,
   output logic o_wbuf_full
);
   localparam int BAW = ddri_pkg::BAW;
   localparam int DW = ddri_pkg::DW;
   localparam int COLW = ddri_pkg::COLW;
   localparam int ROWK = ddri_pkg::ROWK;
   localparam int SW = 10 + BAW + ddri_pkg::AW + DW;
   localparam int FW = ddri_pkg::STORE_AW + DW;

   // ------------------------------------------------------------
   // Pin synchronisers and edge finding
   // ------------------------------------------------------------
   logic s_ck, s_ck_n, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n;
   logic s_odt, s_dqs, s_dm;
   logic [BAW-1:0] s_ba;
   logic [ddri_pkg::AW-1:0] s_a;
   logic [DW-1:0] s_dq;
   logic ck_q_reg;
   logic dqs_q_reg;

   ddri_sync #(.W(SW)) u_sync (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_d({i_ck, i_ck_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
            i_ba, i_a, i_odt, i_dq, i_dqs, i_dm}),
      .o_q({s_ck, s_ck_n, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n,
            s_ba, s_a, s_odt, s_dq, s_dqs, s_dm})
   );

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ck_q_reg <= 1'b0;
         dqs_q_reg <= 1'b0;
      end else begin
         ck_q_reg <= s_ck;
         dqs_q_reg <= s_dqs;
      end
   end

   wire ck_rise = s_ck && !ck_q_reg && !s_ck_n;
   wire ck_fall = !s_ck && ck_q_reg && s_ck_n;
   wire dqs_edge = s_dqs ^ dqs_q_reg;

   // ------------------------------------------------------------
   // Command decode, clock enable and termination
   // ------------------------------------------------------------
   ddri_pkg::ddri_cmd_t cmd;
   assign cmd = ddri_pkg::ddri_cmd_t'({s_cs_n, s_ras_n, s_cas_n, s_we_n});
   wire cmd_go = ck_rise && s_cke && !s_cs_n;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_clk_active <= 1'b0;
         o_odt_on <= 1'b0;
      end else if (ck_rise) begin
         o_clk_active <= s_cke;
         o_odt_on <= s_odt;
      end
   end

   // ------------------------------------------------------------
   // Settings words
   // ------------------------------------------------------------
   logic [2:0] cl_reg;
   logic [2:0] al_reg;
   logic bl8_reg;
   logic complementary_read_side_strobe_en_reg;
   logic dqs_n_off_reg;
   logic [2:0] cl_code;
   logic [2:0] bl_code;
   assign cl_code = s_a[ddri_pkg::CL_MSB:ddri_pkg::CL_LSB];
   assign bl_code = s_a[ddri_pkg::BL_MSB:ddri_pkg::BL_LSB];

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cl_reg <= ddri_pkg::CL_RESET;
         al_reg <= ddri_pkg::AL_RESET;
         bl8_reg <= 1'b0;
         complementary_read_side_strobe_en_reg <= 1'b0;
         dqs_n_off_reg <= 1'b0;
      end else if (cmd_go && cmd == ddri_pkg::CMD_MRS) begin
         if (s_ba == ddri_pkg::BA_MODE) begin
            // Unsupported codes leave the old latency in place
            if (cl_code >= ddri_pkg::CL_MIN && cl_code <= ddri_pkg::CL_MAX) begin
               cl_reg <= cl_code;
            end
            if (bl_code == ddri_pkg::BL8_CODE) begin
               bl8_reg <= 1'b1;
            end else if (bl_code == ddri_pkg::BL4_CODE) begin
               bl8_reg <= 1'b0;
            end
         end else if (s_ba == ddri_pkg::BA_EXT1) begin
            al_reg <= s_a[ddri_pkg::AL_MSB:ddri_pkg::AL_LSB];
            complementary_read_side_strobe_en_reg <= s_a[ddri_pkg::COMPLEMENTARY_READ_SIDE_STROBE_BIT];
            dqs_n_off_reg <= s_a[ddri_pkg::DQSN_OFF_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Bank state
   // ------------------------------------------------------------
   logic [ROWK-1:0] rowk [ddri_pkg::NB];
   logic rd_close_reg;
   logic wr_close_reg;
   logic [BAW-1:0] rd_bank_reg;
   logic [BAW-1:0] wr_bank_reg;

   for (genvar b = 0; b < ddri_pkg::NB; b++) begin : g_bank
      logic open_reg;
      logic [ROWK-1:0] rowk_reg;
      wire hit = s_ba == BAW'(b);
      assign o_bank_open[b] = open_reg;
      assign rowk[b] = rowk_reg;
      always_ff @(posedge i_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            open_reg <= 1'b0;
            rowk_reg <= '0;
         end else if (cmd_go && cmd == ddri_pkg::CMD_ACT && hit) begin
            open_reg <= 1'b1;
            rowk_reg <= s_a[ROWK-1:0];
         end else if (cmd_go && cmd == ddri_pkg::CMD_PRE &&
                      (hit || s_a[ddri_pkg::AP_BIT])) begin
            open_reg <= 1'b0;
         end else if ((rd_close_reg && rd_bank_reg == BAW'(b)) ||
                      (wr_close_reg && wr_bank_reg == BAW'(b))) begin
            open_reg <= 1'b0;
         end
      end
   end

   function automatic logic [COLW-1:0] col_next(input logic [COLW-1:0] c,
                                                input logic b8);
      col_next = b8 ? {c[COLW-1:3], c[2:0] + 3'h1} : {c[COLW-1:2], c[1:0] + 2'h1};
   endfunction : col_next

   logic [3:0] bl_len;
   assign bl_len = bl8_reg ? ddri_pkg::BL8 : ddri_pkg::BL4;

   // ------------------------------------------------------------
   // Write capture into the buffer
   // ------------------------------------------------------------
   logic wr_arm_reg;
   logic wr_ap_reg;
   logic [ROWK-1:0] wr_rowk_reg;
   logic [COLW-1:0] wr_col_reg;
   logic [3:0] wr_cnt_reg;
   logic fi_ready, fo_valid;
   logic [FW-1:0] fo_data;
   // Read-strobe mode turns the mask pin into an output, so no masking
   wire dm_masks = s_dm && !complementary_read_side_strobe_en_reg;
   wire wr_beat = wr_arm_reg && dqs_edge;
   wire fi_valid = wr_beat && !dm_masks;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_arm_reg <= 1'b0;
         wr_ap_reg <= 1'b0;
         wr_bank_reg <= '0;
         wr_rowk_reg <= '0;
         wr_col_reg <= '0;
         wr_cnt_reg <= '0;
         wr_close_reg <= 1'b0;
      end else begin
         wr_close_reg <= 1'b0;
         if (cmd_go && cmd == ddri_pkg::CMD_WR && o_bank_open[s_ba]) begin
            wr_arm_reg <= 1'b1;
            wr_bank_reg <= s_ba;
            wr_rowk_reg <= rowk[s_ba];
            wr_col_reg <= s_a[COLW-1:0];
            wr_ap_reg <= s_a[ddri_pkg::AP_BIT];
            wr_cnt_reg <= '0;
         end else if (wr_beat) begin
            wr_col_reg <= col_next(wr_col_reg, bl8_reg);
            wr_cnt_reg <= wr_cnt_reg + 4'h1;
            if (wr_cnt_reg == bl_len - 4'h1) begin
               wr_arm_reg <= 1'b0;
               wr_close_reg <= wr_ap_reg;
            end
         end
      end
   end

   ddri_pkg::ddri_rd_t rd_state;

   // A burst being read owns the array, so the buffer holds writes meanwhile
   ddri_fifo #(.W(FW), .D(ddri_pkg::FIFO_DEPTH)) u_wbuf (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(fi_valid),
      .o_in_ready(fi_ready),
      .i_in_data({wr_bank_reg, wr_rowk_reg, wr_col_reg, s_dq}),
      .o_out_valid(fo_valid),
      .i_out_ready(rd_state == ddri_pkg::RD_IDLE),
      .o_out_data(fo_data)
   );

   logic [DW-1:0] mem_reg [ddri_pkg::MEM_WORDS];

   always_ff @(posedge i_clk) begin
      if (fo_valid && rd_state == ddri_pkg::RD_IDLE) begin
         mem_reg[fo_data[FW-1:DW]] <= fo_data[DW-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_wbuf_full <= 1'b0;
      end else begin
         o_wbuf_full <= !fi_ready;
      end
   end

   // ------------------------------------------------------------
   // Read sequencer
   // ------------------------------------------------------------
   logic [3:0] rd_wait_reg;
   logic [3:0] rd_cnt_reg;
   logic [ROWK-1:0] rd_rowk_reg;
   logic [COLW-1:0] rd_col_reg;
   logic rd_ap_reg;
   logic drv_reg;
   logic dqs_reg;
   logic [DW-1:0] dq_reg;
   wire [ddri_pkg::STORE_AW-1:0] rd_addr = {rd_bank_reg, rd_rowk_reg, rd_col_reg};

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_state <= ddri_pkg::RD_IDLE;
         rd_wait_reg <= '0;
         rd_cnt_reg <= '0;
         rd_bank_reg <= '0;
         rd_rowk_reg <= '0;
         rd_col_reg <= '0;
         rd_ap_reg <= 1'b0;
         rd_close_reg <= 1'b0;
         drv_reg <= 1'b0;
         dqs_reg <= 1'b0;
         dq_reg <= '0;
      end else begin
         rd_close_reg <= 1'b0;
         unique case (rd_state)
            ddri_pkg::RD_IDLE: begin
               // A second read during a burst is not queued
               if (cmd_go && cmd == ddri_pkg::CMD_RD && o_bank_open[s_ba]) begin
                  rd_state <= ddri_pkg::RD_WAIT;
                  rd_bank_reg <= s_ba;
                  rd_rowk_reg <= rowk[s_ba];
                  rd_col_reg <= s_a[COLW-1:0];
                  rd_ap_reg <= s_a[ddri_pkg::AP_BIT];
                  rd_wait_reg <= {1'b0, al_reg} + {1'b0, cl_reg};
               end
            end
            ddri_pkg::RD_WAIT: begin
               if (ck_rise) begin
                  if (rd_wait_reg == 4'h1) begin
                     rd_state <= ddri_pkg::RD_BURST;
                     drv_reg <= 1'b1;
                     dqs_reg <= 1'b1;
                     dq_reg <= mem_reg[rd_addr];
                     rd_col_reg <= col_next(rd_col_reg, bl8_reg);
                     rd_cnt_reg <= 4'h1;
                  end else begin
                     rd_wait_reg <= rd_wait_reg - 4'h1;
                  end
               end
            end
            ddri_pkg::RD_BURST: begin
               if (ck_rise || ck_fall) begin
                  if (rd_cnt_reg == bl_len) begin
                     rd_state <= ddri_pkg::RD_IDLE;
                     drv_reg <= 1'b0;
                     dqs_reg <= 1'b0;
                     rd_close_reg <= rd_ap_reg;
                  end else begin
                     dqs_reg <= ck_rise;
                     dq_reg <= mem_reg[rd_addr];
                     rd_col_reg <= col_next(rd_col_reg, bl8_reg);
                     rd_cnt_reg <= rd_cnt_reg + 4'h1;
                  end
               end
            end
            default: begin
               rd_state <= ddri_pkg::RD_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin drivers, one register stage
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_dq <= '0;
         o_dq_oe_n <= 1'b1;
         o_dqs <= 1'b0;
         o_dqs_oe_n <= 1'b1;
         o_dqs_n <= 1'b1;
         o_dqs_n_oe_n <= 1'b1;
         o_complementary_read_side_strobe <= 1'b0;
         o_complementary_read_side_strobe_oe_n <= 1'b1;
         o_complementary_read_side_strobe_n <= 1'b1;
         o_complementary_read_side_strobe_n_oe_n <= 1'b1;
      end else begin
         o_dq <= dq_reg;
         o_dq_oe_n <= !drv_reg;
         o_dqs <= dqs_reg;
         o_dqs_oe_n <= !drv_reg;
         o_dqs_n <= !dqs_reg;
         o_dqs_n_oe_n <= !(drv_reg && !dqs_n_off_reg);
         o_complementary_read_side_strobe <= dqs_reg;
         o_complementary_read_side_strobe_oe_n <= !(drv_reg && complementary_read_side_strobe_en_reg);
         o_complementary_read_side_strobe_n <= !dqs_reg;
         o_complementary_read_side_strobe_n_oe_n <= !(drv_reg && complementary_read_side_strobe_en_reg && !dqs_n_off_reg);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   property p_cs_masks;
      ck_rise && s_cs_n && rd_state == ddri_pkg::RD_IDLE |=> rd_state == ddri_pkg::RD_IDLE;
   endproperty
   a_cs_masks: assert property (p_cs_masks) else $error("read started with cs high");

   property p_cross_only;
      !ck_rise |=> $stable(cl_reg) && $stable(al_reg) && $stable(o_odt_on);
   endproperty
   a_cross_only: assert property (p_cross_only) else $error("pins taken off crossing");

   property p_cke;
      ck_rise |=> o_clk_active == $past(s_cke);
   endproperty
   a_cke: assert property (p_cke) else $error("clock enable not taken");

   property p_odt;
      ck_rise ##1 !ck_rise |=> o_odt_on == $past(s_odt, 2);
   endproperty
   a_odt: assert property (p_odt) else $error("termination not following input");

   property p_mask;
      wr_beat && !complementary_read_side_strobe_en_reg && s_dm |-> !fi_valid;
   endproperty
   a_mask: assert property (p_mask) else $error("masked beat stored");

   property p_complementary_read_side_strobe_nomask;
      wr_beat && complementary_read_side_strobe_en_reg |-> fi_valid;
   endproperty
   a_complementary_read_side_strobe_nomask: assert property (p_complementary_read_side_strobe_nomask) else $error("mask used in strobe mode");

   property p_dqsn_off;
      $past(dqs_n_off_reg) |-> o_dqs_n_oe_n && o_complementary_read_side_strobe_n_oe_n;
   endproperty
   a_dqsn_off: assert property (p_dqsn_off) else $error("complement strobe driven");

   property p_rdqsn;
      !o_complementary_read_side_strobe_n_oe_n |-> !o_complementary_read_side_strobe_oe_n && !o_dqs_n_oe_n;
   endproperty
   a_rdqsn: assert property (p_rdqsn) else $error("complement read strobe alone");

   property p_latency;
      rd_state == ddri_pkg::RD_IDLE && cmd_go && cmd == ddri_pkg::CMD_RD && o_bank_open[s_ba]
      |=> rd_wait_reg == {1'b0, $past(al_reg)} + {1'b0, $past(cl_reg)};
   endproperty
   a_latency: assert property (p_latency) else $error("read latency wrong");

   property p_beat;
      rd_state == ddri_pkg::RD_BURST && (ck_rise || ck_fall) && rd_cnt_reg != bl_len
      |=> drv_reg && dqs_reg == $past(ck_rise) ##1 !o_dq_oe_n && o_dqs == $past(dqs_reg);
   endproperty
   a_beat: assert property (p_beat) else $error("read beat not on crossing");
endmodule : ddri_dev
`default_nettype wire

// [src/ddri_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module ddri_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   // Depth must be a power of two; pointers carry one wrap bit
   localparam int PW = $clog2(D);
   logic [W-1:0] mem_reg [D];
   logic [PW:0] wp_reg;
   logic [PW:0] rp_reg;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;

   assign o_in_ready = (wp_reg ^ rp_reg) != {1'b1, {PW{1'b0}}};
   assign o_out_valid = wp_reg != rp_reg;
   assign o_out_data = mem_reg[rp_reg[PW-1:0]];

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= wp_reg + (PW + 1)'(1);
         end
         if (pop) begin
            rp_reg <= rp_reg + (PW + 1)'(1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wp_reg[PW-1:0]] <= i_in_data;
      end
   end
endmodule : ddri_fifo
`default_nettype wire

// [src/ddri_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module ddri_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_reg <= '0;
         o_q <= '0;
      end else begin
         meta_reg <= i_d;
         o_q <= meta_reg;
      end
   end
endmodule : ddri_sync
`default_nettype wire

// [testbench/ddri_ctl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Memory controller side of the link
// ----------------------------------------
module ddri_ctl_model (
   input wire logic i_clk,
   output logic o_ck,
   output logic o_ck_n,
   output logic o_cke,
   output logic o_odt,
   output logic [3:0] o_cmd,
   output logic [ddri_pkg::BAW-1:0] o_ba,
   output logic [ddri_pkg::AW-1:0] o_a,
   output logic [ddri_pkg::DW-1:0] o_dq,
   output logic o_dqs,
   output logic o_dm
);
   int rises = 0;
   initial begin
      {o_ck, o_ck_n, o_cke, o_odt, o_dqs, o_dm} = 6'b011000;
      o_cmd = 4'hf;
      {o_ba, o_a, o_dq} = '0;
   end
   // One 80 ns link cycle; the link clock stands low between calls
   task automatic lc(input logic [3:0] c, input logic [1:0] b, input logic [13:0] ad);
      @(posedge i_clk);
      o_cmd <= c;
      o_ba <= b;
      o_a <= ad;
      repeat (4) @(posedge i_clk);
      {o_ck, o_ck_n} <= 2'b10;
      rises++;
      repeat (5) @(posedge i_clk);
      {o_ck, o_ck_n} <= 2'b01;
      o_cmd <= 4'hf;
      o_a <= ~ad;
   endtask : lc
   // Strobe edges sit mid-beat, three cycles clear of each data change
   task automatic wr(input logic [1:0] b, input logic [13:0] ad, input int bl, input int rl,
                     input logic [63:0] d, input logic [7:0] m);
      lc(4'b0100, b, ad);
      repeat (rl - 1) lc(4'b1111, 2'h0, 14'h0);
      for (int k = 0; k < bl; k++) begin
         @(posedge i_clk);
         o_dq <= d[8*k +: 8];
         o_dm <= m[k];
         repeat (3) @(posedge i_clk);
         o_dqs <= ~o_dqs;
         repeat (3) @(posedge i_clk);
      end
      o_dq <= ~o_dq;
   endtask : wr
endmodule : ddri_ctl_model
`default_nettype wire

// [testbench/ddri_dev_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module ddri_dev_tb_top;
   // ----------------------------------------
   // Clock, reset and wiring
   // ----------------------------------------
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int r0 = 0;
   int lat = 0;
   logic ck, ck_n, cke, odt, dqs, dm, pdqs, poe, dqs_o, dq_oe_n, dqs_oe_n;
   logic dqsn, dqsn_oe_n, rq, rq_oe_n, rqn, rqn_oe_n, odt_on, clk_act, wbuf_full;
   logic [3:0] cmd, bank_open, seen;
   logic [1:0] ba;
   logic [13:0] a;
   logic [7:0] dq, rdq;
   logic [7:0] q[$];
   always #4 clk = ~clk;
   ddri_ctl_model i_ddri_ctl_model (.i_clk(clk), .o_ck(ck), .o_ck_n(ck_n), .o_cke(cke),
      .o_odt(odt), .o_cmd(cmd), .o_ba(ba), .o_a(a), .o_dq(dq), .o_dqs(dqs), .o_dm(dm));
   ddri_dev i_ddri_dev (.i_clk(clk), .i_arst_n(arst_n), .i_ck(ck), .i_ck_n(ck_n),
      .i_cke(cke), .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
      .i_ba(ba), .i_a(a), .i_odt(odt), .i_dq(dq), .i_dqs(dqs), .i_dm(dm), .o_dq(rdq),
      .o_dq_oe_n(dq_oe_n), .o_dqs(dqs_o), .o_dqs_oe_n(dqs_oe_n), .o_dqs_n(dqsn),
      .o_dqs_n_oe_n(dqsn_oe_n), .o_complementary_read_side_strobe(rq), .o_complementary_read_side_strobe_oe_n(rq_oe_n), .o_complementary_read_side_strobe_n(rqn),
      .o_complementary_read_side_strobe_n_oe_n(rqn_oe_n), .o_odt_on(odt_on), .o_clk_active(clk_act),
      .o_bank_open(bank_open), .o_wbuf_full(wbuf_full));
   // A new beat shows as a strobe flip, so equal data in a row still counts
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         complete_run();
      end
      pdqs <= dqs_o;
      poe <= dq_oe_n;
      if (dq_oe_n === 1'b0 && (poe !== 1'b0 || dqs_o !== pdqs)) begin
         if (q.size() == 0) lat = i_ddri_ctl_model.rises - r0;
         q.push_back(rdq);
      end
      // Low bit flags any driven strobe copy that disagrees with the true strobe
      seen <= seen | {~rq_oe_n, ~rqn_oe_n, ~dqsn_oe_n,
                      (~dqsn_oe_n & (dqsn ~^ dqs_o)) | (~rq_oe_n & (rq ^ dqs_o)) |
                      (~rqn_oe_n & (rqn ~^ dqs_o))};
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
      comparisons++;
      if (sv !== ev) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, sv, ev);
      end
   endtask : chk
   task automatic rd(input logic [1:0] b, input logic [13:0] ad, input int bl, input int rl,
                     input logic [63:0] d, input logic [3:0] fl);
      @(negedge clk);
      q.delete();
      lat = 0;
      seen = 4'h0;
      i_ddri_ctl_model.lc(4'b0101, b, ad);
      r0 = i_ddri_ctl_model.rises;
      repeat (rl + bl / 2 + 2) i_ddri_ctl_model.lc(4'b1111, 2'h0, 14'h0);
      chk(q.size(), bl);
      chk(lat, rl);
      for (int k = 0; k < bl; k++) chk(q[k], d[8*k +: 8]);
      chk(seen, fl);
   endtask : rd
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_gate();
      i_ddri_ctl_model.o_odt <= 1'b1;
      i_ddri_ctl_model.lc(4'b1011, 2'h3, 14'h0005);
      i_ddri_ctl_model.o_cke <= 1'b0;
      i_ddri_ctl_model.lc(4'b0011, 2'h3, 14'h0005);
      repeat (2) @(posedge clk);
      chk(bank_open, 4'h0);
      chk(clk_act, 1'b0);
      chk(odt_on, 1'b1);
      i_ddri_ctl_model.o_cke <= 1'b1;
      i_ddri_ctl_model.lc(4'b0011, 2'h2, 14'h0005);
      repeat (2) @(posedge clk);
      chk(clk_act, 1'b1);
      chk(bank_open, 4'h4);
      $display("Test gate done");
   endtask : t_gate
   // Second write masks beat 1, so the first write's byte must survive
   task automatic t_mask();
      i_ddri_ctl_model.wr(2'h2, 14'h0008, 4, 3, 64'h44332211, 8'h00);
      i_ddri_ctl_model.wr(2'h2, 14'h0008, 4, 3, 64'hd4c3b2a1, 8'h02);
      rd(2'h2, 14'h0008, 4, 3, 64'hd4c322a1, 4'h2);
      chk(wbuf_full, 1'b0);
      $display("Test mask done");
   endtask : t_mask
   task automatic t_modes();
      i_ddri_ctl_model.lc(4'b0000, ddri_pkg::BA_MODE, 14'h0053);
      i_ddri_ctl_model.lc(4'b0000, ddri_pkg::BA_EXT1, 14'h0808);
      i_ddri_ctl_model.wr(2'h2, 14'h0010, 8, 6, 64'h4746454443424140, 8'h04);
      rd(2'h2, 14'h0410, 8, 6, 64'h4746454443424140, 4'he);
      chk(bank_open, 4'h0);
      i_ddri_ctl_model.lc(4'b0000, ddri_pkg::BA_EXT1, 14'h0c08);
      i_ddri_ctl_model.lc(4'b0011, 2'h2, 14'h0005);
      rd(2'h2, 14'h0010, 8, 6, 64'h4746454443424140, 4'h8);
      chk(bank_open, 4'h4);
      i_ddri_ctl_model.lc(4'b0010, 2'h0, 14'h0400);
      repeat (2) @(posedge clk);
      chk(bank_open, 4'h0);
      $display("Test modes done");
   endtask : t_modes
   initial begin
      seen = 4'h0;
      repeat (3) @(posedge clk);
      chk({dq_oe_n, dqs_oe_n, dqsn_oe_n, rq_oe_n, rqn_oe_n, dqsn, rqn, bank_open}, 11'h7f0);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_gate();
      t_mask();
      t_modes();
      complete_run();
   end
endmodule : ddri_dev_tb_top
`default_nettype wire
